// ---- rtl/fault_interrupt_enable_bank.sv ----
`timescale 1ns/1ps
module fault_interrupt_enable_bank (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port from the serial interface
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Latched faults from the status side
  input wire logic [fault_irq_pkg::FAULT_COUNT-1:0] fault_latched,
  // Interrupt request
  output logic irq
);
  import fault_irq_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire logic sel_primary = reg_addr == PRIMARY_OFFSET;
  wire logic sel_led = reg_addr == LED_OFFSET;
  wire logic sel_supply = reg_addr == SUPPLY_OFFSET; // [R10]
  wire logic [15:0] primary_value;
  wire logic [15:0] led_value;
  wire logic [15:0] supply_value;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  enable_reg #(.RESET_VALUE(PRIMARY_RESET), .FIELD_MASK(PRIMARY_FIELDS)) u_primary ( // [R4]
    .clock(clock),
    .reset(reset),
    .wr_en(reg_wr && sel_primary),
    .wr_data(reg_wdata),
    .value(primary_value)
  );

  enable_reg #(.RESET_VALUE(LED_RESET), .FIELD_MASK(LED_FIELDS)) u_led ( // [R5] [R9]
    .clock(clock),
    .reset(reset),
    .wr_en(reg_wr && sel_led),
    .wr_data(reg_wdata),
    .value(led_value)
  );

  enable_reg #(.RESET_VALUE(SUPPLY_RESET), .FIELD_MASK(SUPPLY_FIELDS)) u_supply ( // [R8] [R10]
    .clock(clock),
    .reset(reset),
    .wr_en(reg_wr && sel_supply),
    .wr_data(reg_wdata),
    .value(supply_value)
  );

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire logic [15:0] rd_mux = sel_primary ? primary_value :
      sel_led ? led_value :
      sel_supply ? supply_value : 16'h0000;

  logic [15:0] reg_rdata_r;
  logic reg_rvalid_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata_r <= 16'h0000;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rdata_r <= reg_rd ? rd_mux : reg_rdata_r;
      reg_rvalid_r <= reg_rd;
    end
  end
  assign reg_rdata = reg_rdata_r;
  assign reg_rvalid = reg_rvalid_r;

  // ----------------------------------------
  // Enable fields by source
  // ----------------------------------------
  // A field is on while it reads 2h
  function automatic logic is_on(input logic [1:0] f);
    return f[1]; // [R1]
  endfunction

  // Primary register
  wire logic global_en = is_on(primary_value[GLOBAL_POS+:2]); // [R4]
  wire logic boost_overvolt_high_en = is_on(primary_value[BOOST_OVH_POS+:2]);
  wire logic temperature_en = is_on(primary_value[TEMP_POS+:2]);
  wire logic boost_overvolt_low_en = is_on(primary_value[BOOST_OVL_POS+:2]);
  wire logic boost_overcurrent_en = is_on(primary_value[BOOST_OC_POS+:2]);
  wire logic core_supply_lockout_en = is_on(primary_value[CORE_LOCKOUT_POS+:2]);
  wire logic thermal_shutdown_en = is_on(primary_value[THERMAL_POS+:2]);
  // Second register
  wire logic string_open_short_en = is_on(led_value[STRING_OS_POS+:2]); // [R5]
  // Third register
  wire logic boost_sync_missing_en = is_on(supply_value[BOOST_SYNC_POS+:2]); // [R6]
  wire logic input_overcurrent_en = is_on(supply_value[INPUT_OC_POS+:2]);
  wire logic pump_cap_missing_en = is_on(supply_value[PUMP_CAP_POS+:2]);
  wire logic pump_fault_en = is_on(supply_value[PUMP_FAULT_POS+:2]);
  wire logic freq_resistor_missing_en = is_on(supply_value[FREQ_RES_POS+:2]); // [R7]
  wire logic bad_string_config_en = is_on(supply_value[BAD_STRING_POS+:2]);
  wire logic input_overvolt_en = is_on(supply_value[INPUT_OV_POS+:2]);
  wire logic input_undervolt_en = is_on(supply_value[INPUT_UV_POS+:2]);

  // ----------------------------------------
  // Interrupt gating
  // ----------------------------------------
  // One enable per fault_latched bit, highest bit first
  wire logic [FAULT_COUNT-1:0] source_en = {
    boost_overvolt_high_en,
    temperature_en,
    boost_overvolt_low_en,
    boost_overcurrent_en,
    core_supply_lockout_en,
    thermal_shutdown_en,
    string_open_short_en,
    boost_sync_missing_en,
    input_overcurrent_en,
    pump_cap_missing_en,
    pump_fault_en,
    freq_resistor_missing_en,
    bad_string_config_en,
    input_overvolt_en,
    input_undervolt_en
  };
  wire logic [FAULT_COUNT-1:0] fault_gated;

  genvar s;
  generate
    for (s = 0; s < FAULT_COUNT; s++) begin : g_gate
      assign fault_gated[s] = fault_latched[s] && source_en[s]; // [R12]
    end
  endgenerate

  // A fault cleared on the status side drops out here on the next edge
  wire logic irq_nxt = global_en && (|fault_gated); // [R12] [R11]

  logic irq_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end
  assign irq = irq_r;
endmodule // fault_interrupt_enable_bank

// ---- rtl/fault_irq_pkg.sv ----
// Contract
// R1 - Each enable field is two bits and reads 0h when disabled and 2h when enabled.
// R2 - Writing 1h to an enable field disables that source and writing 3h enables it.
// R3 - Writing 0h or 2h to an enable field leaves its state unchanged.
// R4 - The primary register at 50h resets to A02Ah with global, boost, thermal and supply fields.
// R5 - The second register at 52h resets to 80h with the string open/short enable in bits 7-6.
// R6 - Third register bits 15-8 hold boost sync, input overcurrent, pump cap and pump fault enables.
// R7 - Third register bits 7-0 hold resistor, string config, input overvolt and undervolt enables.
// R8 - After reset the third register shows input overcurrent, overvolt and undervolt enabled.
// R9 - Reserved bits are plain read/write storage that reset to zero and do nothing.
// R10 - The third register sits at offset 4Eh and resets to 200Ah.
// R11 - A latched fault clears only when the host writes one to its status and clear bits together.
// R12 - A latched fault drives the interrupt only while its own enable and the global enable are on.
package fault_irq_pkg;
  localparam logic [7:0] PRIMARY_OFFSET = 8'h50;
  localparam logic [7:0] LED_OFFSET = 8'h52;
  localparam logic [7:0] SUPPLY_OFFSET = 8'h4E;
  localparam logic [15:0] PRIMARY_RESET = 16'hA02A;
  localparam logic [15:0] LED_RESET = 16'h0080;
  localparam logic [15:0] SUPPLY_RESET = 16'h200A;
  // Field codes
  localparam logic [1:0] CODE_DIS_READ = 2'h0;
  localparam logic [1:0] CODE_DISABLE = 2'h1;
  localparam logic [1:0] CODE_EN_READ = 2'h2;
  localparam logic [1:0] CODE_ENABLE = 2'h3;
  // Primary register field positions (low bit of each field)
  localparam int GLOBAL_POS = 14;
  localparam int BOOST_OVH_POS = 12;
  localparam int TEMP_POS = 10;
  localparam int BOOST_OVL_POS = 6;
  localparam int BOOST_OC_POS = 4;
  localparam int CORE_LOCKOUT_POS = 2;
  localparam int THERMAL_POS = 0;
  // Second register
  localparam int STRING_OS_POS = 6;
  // Third register
  localparam int BOOST_SYNC_POS = 14;
  localparam int INPUT_OC_POS = 12;
  localparam int PUMP_CAP_POS = 10;
  localparam int PUMP_FAULT_POS = 8;
  localparam int FREQ_RES_POS = 6;
  localparam int BAD_STRING_POS = 4;
  localparam int INPUT_OV_POS = 2;
  localparam int INPUT_UV_POS = 0;
  // Field masks: fields are command-coded, the rest plain storage
  localparam logic [15:0] PRIMARY_FIELDS = 16'hFCFF;
  localparam logic [15:0] LED_FIELDS = 16'h00C0;
  localparam logic [15:0] SUPPLY_FIELDS = 16'hFFFF;
  localparam int FAULT_COUNT = 15;
endpackage

// ---- rtl/enable_reg.sv ----
`timescale 1ns/1ps
module enable_reg #(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [15:0] FIELD_MASK = 16'h0000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Write port
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  // Stored value
  output logic [15:0] value
);
  import fault_irq_pkg::*;

  logic [15:0] value_r;
  logic [15:0] value_nxt;

  // Apply one field's command code
  function automatic logic [1:0] field_next(input logic [1:0] cur, input logic [1:0] code);
    logic [1:0] res;
    res = cur;
    if (code == CODE_DISABLE) begin
      res = CODE_DIS_READ; // [R2] [R1]
    end else if (code == CODE_ENABLE) begin
      res = CODE_EN_READ; // [R2] [R1]
    end
    // 0h and 2h keep the state [R3]
    return res;
  endfunction

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_field
      localparam int LO = 2 * g;
      wire logic is_field = FIELD_MASK[LO];
      wire logic [1:0] coded = field_next(value_r[LO+1:LO], wr_data[LO+1:LO]);
      assign value_nxt[LO+1:LO] = !wr_en ? value_r[LO+1:LO] :
          (is_field ? coded : wr_data[LO+1:LO]); // [R9]
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (reset) begin
      value_r <= RESET_VALUE;
    end else begin
      value_r <= value_nxt;
    end
  end

  assign value = value_r;
endmodule // enable_reg

// ---- verification/fault_enable_monitor.sv ----
`timescale 1ns/1ps
module fault_enable_monitor (
  // Clock and reset
  input logic clock,
  input logic reset,
  // Register port
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic [15:0] reg_rdata,
  input logic reg_rvalid,
  // Faults
  input logic [fault_irq_pkg::FAULT_COUNT-1:0] fault_latched,
  input logic irq
);
  import fault_irq_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_rv; reg_rd |=> reg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  property p_um; reg_rd && !(reg_addr inside {8'h4E, 8'h50, 8'h52}) |=> reg_rdata == 0; endproperty
  a_um: assert property (p_um) else $error("unmapped data");
  property p_c3; reg_rvalid && $past(reg_addr) == 8'h4E |-> (reg_rdata & 16'h5555) == 0; endproperty
  a_c3: assert property (p_c3) else $error("odd code");
  property p_c1; reg_rvalid && $past(reg_addr) == 8'h50 |-> (reg_rdata & 16'h5455) == 0; endproperty
  a_c1: assert property (p_c1) else $error("odd code");
  property p_ds; reg_wr && reg_addr == 8'h4E && reg_wdata == 16'h0001 ##2
    reg_rd && reg_addr == 8'h4E |=> reg_rdata[1:0] == 2'h0; endproperty
  a_ds: assert property (p_ds) else $error("not disabled");
  property p_qt; fault_latched == 0 |=> !irq; endproperty
  a_qt: assert property (p_qt) else $error("irq no fault");
  property p_gl; reg_wr && reg_addr == 8'h50 && reg_wdata[15:14] == 2'h1 |=> ##1 !irq; endproperty
  a_gl: assert property (p_gl) else $error("irq no global");
  property p_rs; $fell(reset) |-> reg_rdata == 0 && !irq; endproperty
  a_rs: assert property (p_rs) else $error("bad reset");
endmodule // fault_enable_monitor
bind fault_interrupt_enable_bank fault_enable_monitor fault_enable_monitor_i (.clock(clock),
  .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fault_latched(fault_latched), .irq(irq));

// ---- verification/reg_host.sv ----
`timescale 1ns/1ps
module reg_host (
  // Clock
  input logic clock,
  // Register port
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [15:0] reg_wdata = 16'h0000,
  input logic [15:0] reg_rdata,
  input logic reg_rvalid
);
  // Fields carry 1h to disable and 3h to enable
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rvalid ? reg_rdata : 'x;
  endtask
endmodule // reg_host

// ---- verification/fault_interrupt_enable_bank_tb.sv ----
`timescale 1ns/1ps
module fault_interrupt_enable_bank_tb;
  import fault_irq_pkg::*;
  typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  typedef struct {logic [7:0] a; logic [15:0] d;} src_t;
  localparam logic [FAULT_COUNT-1:0] ONE_FAULT = {{(FAULT_COUNT-1){1'b0}}, 1'b1};
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid, irq;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, got;
  logic [FAULT_COUNT-1:0] fault_latched = '0;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  row_t rows [11] = '{'{8'h4E, 16'h0000, 16'h200A}, '{8'h4E, 16'hFFFF, 16'hAAAA},
    '{8'h4E, 16'h5555, 16'h0000}, '{8'h4E, 16'hAAAA, 16'h0000}, '{8'h50, 16'h0300, 16'hA32A},
    '{8'h50, 16'h5455, 16'h0000}, '{8'h50, 16'hFCFF, 16'hA8AA}, '{8'h52, 16'hFF3F, 16'hFFBF},
    '{8'h52, 16'h0040, 16'h0000}, '{8'h52, 16'h00C0, 16'h0080}, '{8'h60, 16'hFFFF, 16'h0000}};
  // Disable code of the field that gates each fault bit, bit 0 first
  src_t srcs [FAULT_COUNT] = '{'{8'h4E, 16'h0001}, '{8'h4E, 16'h0004}, '{8'h4E, 16'h0010},
    '{8'h4E, 16'h0040}, '{8'h4E, 16'h0100}, '{8'h4E, 16'h0400}, '{8'h4E, 16'h1000},
    '{8'h4E, 16'h4000}, '{8'h52, 16'h0040}, '{8'h50, 16'h0001}, '{8'h50, 16'h0004},
    '{8'h50, 16'h0010}, '{8'h50, 16'h0040}, '{8'h50, 16'h0400}, '{8'h50, 16'h1000}};
  always #4 clock = ~clock;
  fault_interrupt_enable_bank fault_interrupt_enable_bank_i (.clock(clock), .reset(reset),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fault_latched(fault_latched), .irq(irq));
  reg_host reg_host_i (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_irq(input logic e);
    n_checks++;
    if (irq !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, irq, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(negedge clock);
    reset = 1'b0;
    foreach (rows[i]) begin
      reg_host_i.wr(rows[i].a, rows[i].d);
      reg_host_i.rd(rows[i].a, got);
      chk(got, rows[i].e);
    end
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    reg_host_i.rd(8'h4E, got);
    chk(got, 16'h200A);
    reg_host_i.rd(8'h50, got);
    chk(got, 16'hA02A);
    reg_host_i.rd(8'h52, got);
    chk(got, 16'h0080);
    fault_latched = ONE_FAULT;
    @(negedge clock);
    chk_irq(1'b1);
    reg_host_i.wr(8'h50, 16'h4000);
    @(negedge clock);
    chk_irq(1'b0);
    reg_host_i.wr(8'h50, 16'hC000);
    reg_host_i.wr(8'h4E, 16'h0001);
    reg_host_i.rd(8'h4E, got);
    chk_irq(1'b0);
    reg_host_i.wr(8'h4E, 16'hFFFF);
    reg_host_i.wr(8'h50, 16'hFCFF);
    for (int i = 0; i < FAULT_COUNT; i++) begin
      fault_latched = ONE_FAULT << i;
      @(negedge clock);
      chk_irq(1'b1);
    end
    foreach (srcs[i]) begin
      reg_host_i.wr(srcs[i].a, srcs[i].d);
      fault_latched = ONE_FAULT << i;
      @(negedge clock);
      chk_irq(1'b0);
      reg_host_i.wr(srcs[i].a, srcs[i].d | (srcs[i].d << 1));
      @(negedge clock);
      chk_irq(1'b1);
    end
    fault_latched = '0;
    @(negedge clock);
    chk_irq(1'b0);
    stop_test();
  end
endmodule // fault_interrupt_enable_bank_tb
